// file: design/hours_pkg.sv
// constants shared by the service-hours counter and its hour time base
// assumes a single 200 mhz core clock and a plain register port
package hours_pkg;

    // counter widths and limits
    localparam int              INTERVAL_W   = 14;
    localparam int              ACC_W        = 17;
    localparam logic [13:0]     INTERVAL_MAX = 14'h270f;
    localparam logic [13:0]     INTERVAL_RST = 14'h03e8;
    localparam logic [16:0]     ACC_MAX      = 17'h1869f;

    // time base
    localparam longint unsigned HOUR_S       = 64'h0000_0000_0000_0e10;
    localparam longint unsigned CLK_HZ       = 64'h0000_0000_0beb_c200;
    localparam longint unsigned HOUR_CYCLES  = HOUR_S * CLK_HZ;
    localparam int              TICK_W       = 40;

    // register port
    localparam int              ADDR_W       = 8;
    localparam logic [7:0]      REG_INTERVAL = 8'h00;
    localparam logic [7:0]      REG_REMAIN   = 8'h04;
    localparam logic [7:0]      REG_ACCUM    = 8'h08;
    localparam logic [7:0]      REG_STATUS   = 8'h0c;
    localparam logic [7:0]      REG_IRQ_STAT = 8'h10;
    localparam logic [7:0]      REG_IRQ_MASK = 8'h14;

    // status register fields
    localparam int              ST_DUE       = 0;
    localparam int              ST_RUN       = 1;
    localparam int              ST_HOLD      = 2;
    localparam int              ST_SAT       = 3;

    // interrupt events
    localparam int              EV_W         = 3;
    localparam int              EV_DUE       = 0;
    localparam int              EV_SAT       = 1;
    localparam int              EV_HOUR      = 2;
    localparam logic [2:0]      IRQ_MASK_RST = 3'h0;

    // counting mode
    typedef enum logic [1:0] {
        CNT_IDLE,
        CNT_RUN,
        CNT_HOLD
    } cnt_mode_e;

endpackage

// file: design/hour_tick.sv
// hour time base: counts core clocks while run is high, pulses tick each full hour
// assumes run is already synchronous; a partial hour is kept while run is low
`timescale 1ns/1ps
module hour_tick #(
    parameter int              W      = hours_pkg::TICK_W,
    parameter longint unsigned PERIOD = hours_pkg::HOUR_CYCLES
) (
    // clock and reset
    input  wire logic core_clk,
    input  wire logic rst_b,
    // control
    input  wire logic run,
    // hour event
    output logic      tick
);

    localparam logic [W-1:0] LAST = W'(PERIOD - 64'h1);

    logic [W-1:0] cnt_r;

    // tick only while running, so a held counter never adds an hour
    assign tick = run && (cnt_r == LAST);

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_r <= '0;
        end else if (tick) begin
            cnt_r <= '0;
        end else if (run) begin
            cnt_r <= cnt_r + W'(1);
        end
    end

    AST_TICK_RUN: assert property (@(posedge core_clk) disable iff (!rst_b)
        !run |=> $stable(cnt_r))
        else $error("hour base moved while stopped");

endmodule

// file: design/service_hours_counter.sv
// operating-hours counter with service interval, due output and interrupt
// assumes pins arrive asynchronously and software uses the plain register port
`timescale 1ns/1ps
module service_hours_counter #(
    parameter longint unsigned HOUR_CYCLES = hours_pkg::HOUR_CYCLES,
    parameter int              TICK_W      = hours_pkg::TICK_W
) (
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst_b,
    // register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    // pins
    input  wire logic        monitor_in,
    input  wire logic        part_reset_in,
    input  wire logic        full_reset_in,
    // outputs
    output logic             service_due,
    output logic             irq
);

////////////////////////////////////////////////////////////////////////////////
// declarations

    logic [2:0]                 sync1_r;
    logic [2:0]                 sync2_r;
    logic                       mon_s;
    logic                       part_s;
    logic                       full_s;
    logic                       hold;
    logic                       run;
    logic                       tick;

    logic [13:0]                interval_r;
    logic [13:0]                remain_r;
    logic [13:0]                remain_nxt;
    logic [16:0]                accum_r;
    logic [16:0]                accum_nxt;
    logic                       due_r;
    logic                       due_nxt;
    hours_pkg::cnt_mode_e       mode_r;

    logic [2:0]                 irq_stat_r;
    logic [2:0]                 irq_mask_r;
    logic [2:0]                 events;
    logic [2:0]                 w1c;
    logic [31:0]                rdata_r;

////////////////////////////////////////////////////////////////////////////////
// helpers

    // out-of-range writes clamp to the largest interval
    function automatic logic [13:0] clamp_interval(input logic [31:0] v);
        logic [13:0] r;
        r = hours_pkg::INTERVAL_MAX;
        if (v <= 32'(hours_pkg::INTERVAL_MAX)) begin
            r = v[13:0];
        end
        return r;
    endfunction

    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        return a == off;
    endfunction

////////////////////////////////////////////////////////////////////////////////
// pin synchronisers

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            sync1_r <= 3'h0;
            sync2_r <= 3'h0;
        end else begin
            sync1_r <= {full_reset_in, part_reset_in, monitor_in};
            sync2_r <= sync1_r;
        end
    end

    assign mon_s  = sync2_r[0];
    assign part_s = sync2_r[1];
    assign full_s = sync2_r[2];

    // either reset input stops the counter whatever the monitored input does
    assign hold   = part_s || full_s;
    assign run    = mon_s && !hold;

////////////////////////////////////////////////////////////////////////////////
// hour time base

    hour_tick #(
        .W      (TICK_W),
        .PERIOD (HOUR_CYCLES)
    ) u_hour_tick (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .run      (run),
        .tick     (tick)
    );

////////////////////////////////////////////////////////////////////////////////
// counters

    always_comb begin
        remain_nxt = remain_r;
        if (hold) begin
            remain_nxt = interval_r;
        end else if (tick && remain_r != 14'h0000) begin
            remain_nxt = remain_r - 14'h0001;
        end
    end

    always_comb begin
        accum_nxt = accum_r;
        if (full_s) begin
            accum_nxt = 17'h00000;
        end else if (part_s) begin
            accum_nxt = accum_r;
        end else if (tick && accum_r != hours_pkg::ACC_MAX) begin
            accum_nxt = accum_r + 17'h00001;
        end
    end

    // due is held low with the reset inputs, so an interval of zero is due once they are let go
    assign due_nxt = !hold && (remain_nxt == 14'h0000);

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            remain_r <= hours_pkg::INTERVAL_RST;
        end else begin
            remain_r <= remain_nxt;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            accum_r <= 17'h00000;
        end else begin
            accum_r <= accum_nxt;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            due_r <= 1'b0;
        end else begin
            due_r <= due_nxt;
        end
    end

    assign service_due = due_r;

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            mode_r <= hours_pkg::CNT_IDLE;
        end else begin
            case (1'b1)
                hold:    mode_r <= hours_pkg::CNT_HOLD;
                mon_s:   mode_r <= hours_pkg::CNT_RUN;
                default: mode_r <= hours_pkg::CNT_IDLE;
            endcase
        end
    end

////////////////////////////////////////////////////////////////////////////////
// interval register

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            interval_r <= hours_pkg::INTERVAL_RST;
        end else if (reg_wr && hit(reg_addr, hours_pkg::REG_INTERVAL)) begin
            interval_r <= clamp_interval(reg_wdata);
        end
    end

////////////////////////////////////////////////////////////////////////////////
// interrupts

    assign events[hours_pkg::EV_DUE]  = due_nxt && !due_r;
    assign events[hours_pkg::EV_SAT]  = (accum_nxt == hours_pkg::ACC_MAX)
                                        && (accum_r != hours_pkg::ACC_MAX);
    assign events[hours_pkg::EV_HOUR] = tick;

    assign w1c = (reg_wr && hit(reg_addr, hours_pkg::REG_IRQ_STAT))
                 ? reg_wdata[2:0] : 3'h0;

    // a new event in the clearing cycle survives the clear
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            irq_stat_r <= 3'h0;
        end else begin
            irq_stat_r <= (irq_stat_r & ~w1c) | events;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            irq_mask_r <= hours_pkg::IRQ_MASK_RST;
        end else if (reg_wr && hit(reg_addr, hours_pkg::REG_IRQ_MASK)) begin
            irq_mask_r <= reg_wdata[2:0];
        end
    end

    assign irq = |(irq_stat_r & irq_mask_r);

////////////////////////////////////////////////////////////////////////////////
// read port

    // reads only sample state, so the counters never see them
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            rdata_r <= 32'h0000_0000;
        end else if (reg_rd) begin
            case (reg_addr)
                hours_pkg::REG_INTERVAL: rdata_r <= {18'h00000, interval_r};
                hours_pkg::REG_REMAIN:   rdata_r <= {18'h00000, remain_r};
                hours_pkg::REG_ACCUM:    rdata_r <= {15'h0000, accum_r};
                hours_pkg::REG_STATUS: begin
                    rdata_r <= 32'h0000_0000;
                    rdata_r[hours_pkg::ST_DUE]  <= due_r;
                    rdata_r[hours_pkg::ST_RUN]  <= mode_r == hours_pkg::CNT_RUN;
                    rdata_r[hours_pkg::ST_HOLD] <= mode_r == hours_pkg::CNT_HOLD;
                    rdata_r[hours_pkg::ST_SAT]  <= accum_r == hours_pkg::ACC_MAX;
                end
                hours_pkg::REG_IRQ_STAT: rdata_r <= {29'h0000_0000, irq_stat_r};
                hours_pkg::REG_IRQ_MASK: rdata_r <= {29'h0000_0000, irq_mask_r};
                default:                 rdata_r <= 32'h0000_0000;
            endcase
        end else begin
            rdata_r <= 32'h0000_0000;
        end
    end

    assign reg_rdata = rdata_r;

////////////////////////////////////////////////////////////////////////////////
// checks

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    sequence s_counting_hour;
        tick && accum_r != hours_pkg::ACC_MAX;
    endsequence

    sequence s_zero_free;
        remain_r == 14'h0000 && !hold;
    endsequence

    AST_ADD_HOUR: assert property (
        s_counting_hour |=> accum_r == $past(accum_r) + 17'h00001
                            && (remain_r == $past(remain_r) - 14'h0001
                                || $past(remain_r) == 14'h0000))
        else $error("hour not accumulated");

    AST_HALT: assert property (
        hold |-> !tick ##1 (accum_r == $past(accum_r) || accum_r == 17'h00000))
        else $error("counted while a reset input was held");

    AST_DUE_AT_ZERO: assert property (
        s_zero_free |=> service_due)
        else $error("service due missing at zero");

    AST_PART_RELOAD: assert property (
        part_s && !full_s |=> remain_r == $past(interval_r)
                              && !service_due && $stable(accum_r))
        else $error("partial reset misbehaved");

    AST_FULL_CLEAR: assert property (
        full_s |=> accum_r == 17'h00000 && !service_due
                   && remain_r == $past(interval_r))
        else $error("full reset misbehaved");

    AST_SATURATE: assert property (
        accum_r == hours_pkg::ACC_MAX && !full_s |=> accum_r == hours_pkg::ACC_MAX)
        else $error("total hours passed the limit");

    AST_INTERVAL_WRITE: assert property (
        reg_wr && reg_addr == hours_pkg::REG_INTERVAL
        && reg_wdata <= 32'h0000_270f |=> interval_r == $past(reg_wdata[13:0]))
        else $error("valid interval not stored");

    AST_READ_REMAIN: assert property (
        reg_rd && reg_addr == hours_pkg::REG_REMAIN
        |=> reg_rdata == {18'h00000, $past(remain_r)})
        else $error("remaining hours read wrong");

    AST_READ_ACCUM: assert property (
        reg_rd && reg_addr == hours_pkg::REG_ACCUM
        |=> reg_rdata == {15'h0000, $past(accum_r)})
        else $error("total hours read wrong");

    AST_DUE_HOLDS: assert property (
        s_zero_free ##1 (!hold)[*2] |-> service_due && remain_r == 14'h0000)
        else $error("due dropped or interval underflowed");

    // a reset input held for a cycle and then let go
    sequence s_reset_pulse;
        hold ##1 !hold;
    endsequence

    AST_RELOAD_AFTER_HOLD: assert property (
        s_reset_pulse |-> remain_r == $past(interval_r) && !service_due)
        else $error("interval not reloaded by a reset input");

    AST_REMAIN_STILL: assert property (
        !hold && !tick |=> $stable(remain_r))
        else $error("remaining hours moved without an hour");

    AST_ACCUM_STILL: assert property (
        !full_s && !tick |=> $stable(accum_r))
        else $error("total hours moved without an hour");

    AST_DUE_EVENT: assert property (
        $rose(service_due) |-> irq_stat_r[hours_pkg::EV_DUE])
        else $error("due rise not flagged");

    // set wins over a clear in the same cycle
    AST_EVENT_WINS: assert property (
        events != 3'h0 |=> (irq_stat_r & $past(events)) == $past(events))
        else $error("interrupt event lost");

    AST_W1C_CLEAR: assert property (
        w1c != 3'h0 && (w1c & events) == 3'h0 |=> (irq_stat_r & $past(w1c)) == 3'h0)
        else $error("status bit not cleared by a one");

    AST_MASK_WRITE: assert property (
        reg_wr && reg_addr == hours_pkg::REG_IRQ_MASK
        |=> irq_mask_r == $past(reg_wdata[2:0]))
        else $error("interrupt mask not stored");

    AST_STATUS_READ: assert property (
        reg_rd && reg_addr == hours_pkg::REG_STATUS
        |=> reg_rdata[hours_pkg::ST_DUE] == $past(due_r)
            && reg_rdata[hours_pkg::ST_SAT] == $past(accum_r == hours_pkg::ACC_MAX))
        else $error("status read wrong");

    // read data stands for one cycle only, so idle reads give zero
    AST_RDATA_IDLE: assert property (
        !reg_rd |=> reg_rdata == 32'h0000_0000)
        else $error("read data stood past its cycle");

endmodule

// file: bench/service_hours_counter_bench.sv
// self-checking bench for the service-hours counter: register port, pins, due and irq
// assumes hours_pkg is compiled first; the hour is shortened to ten core clocks
`timescale 1ns/1ps
module service_hours_counter_bench;
    localparam longint unsigned HOUR = 10;
    logic        core_clk;
    logic        rst_b;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [31:0] reg_rdata;
    logic        monitor_in;
    logic        part_reset_in;
    logic        full_reset_in;
    logic        service_due;
    logic        irq;
    logic [31:0] exp_q[$];
    logic        rd_fl;
    int          err_total;
    int          n_checks;
    int          cyc_n;
    logic [31:0] v;
    logic [31:0] seed_v;

    ////////////////////////////////////////////////////////////////////////////
    service_hours_counter #(
        .HOUR_CYCLES (HOUR)
    ) u_service_hours_counter (
        .core_clk      (core_clk),
        .rst_b         (rst_b),
        .reg_addr      (reg_addr),
        .reg_wdata     (reg_wdata),
        .reg_wr        (reg_wr),
        .reg_rd        (reg_rd),
        .reg_rdata     (reg_rdata),
        .monitor_in    (monitor_in),
        .part_reset_in (part_reset_in),
        .full_reset_in (full_reset_in),
        .service_due   (service_due),
        .irq           (irq)
    );

    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr    <= 1'b0;
    endtask

    // the expected word is noted when the strobe goes out
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge core_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        exp_q.push_back(exp);
        @(posedge core_clk);
        reg_rd   <= 1'b0;
    endtask

    // pins held n cycles; the wait after covers the two-flop synchroniser
    task automatic pins(input logic m, input logic p, input logic f, input int n);
        @(posedge core_clk);
        monitor_in    <= m;
        part_reset_in <= p;
        full_reset_in <= f;
        cyc(n);
        monitor_in    <= 1'b0;
        part_reset_in <= 1'b0;
        full_reset_in <= 1'b0;
        cyc(6);
    endtask

    task automatic pin_chk(input logic due, input logic ir);
        @(negedge core_clk);
        check({31'h0, service_due}, {31'h0, due}, "service_due");
        check({31'h0, irq}, {31'h0, ir}, "irq");
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // read data stands only in the cycle after the strobe, so look mid-cycle
    always @(posedge core_clk) rd_fl <= reg_rd;

    always @(negedge core_clk) begin
        if (rd_fl) begin
            if (exp_q.size() == 0) begin
                check(reg_rdata, 32'hffff_ffff, "unexpected read");
            end else begin
                check(reg_rdata, exp_q.pop_front(), "read data");
            end
        end
    end

    always @(posedge core_clk) begin
        cyc_n <= cyc_n + 1;
        if (cyc_n == 4000) begin
            err_total++;
            $display("wrong value at %0t: run did not finish", $time);
            finish_test();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        rst_b = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 32'h0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        monitor_in = 1'b0;
        part_reset_in = 1'b0;
        full_reset_in = 1'b0;
        rd_fl = 1'b0;
        err_total = 0;
        n_checks = 0;
        cyc_n = 0;
        seed_v = $urandom(17);
        cyc(3);
        rst_b <= 1'b1;
        cyc(1);
        rd(hours_pkg::REG_INTERVAL, 32'h3e8);
        rd(hours_pkg::REG_REMAIN, 32'h3e8);
        rd(hours_pkg::REG_ACCUM, 32'h0);
        rd(hours_pkg::REG_IRQ_MASK, 32'h0);
        rd(8'h18, 32'h0);
        $display("test reset values done");
        // interval accepts 0..9999; larger values pin at the top
        for (int i = 0; i < 8; i++) begin
            v = (i == 0) ? 32'd9999 : (i == 1) ? 32'd10000 : ($urandom % 32'd16384);
            wr(hours_pkg::REG_INTERVAL, v);
            rd(hours_pkg::REG_INTERVAL, (v > 32'd9999) ? 32'd9999 : v);
        end
        wr(hours_pkg::REG_INTERVAL, 32'd3);
        pins(1'b0, 1'b0, 1'b1, 4);
        rd(hours_pkg::REG_REMAIN, 32'd3);
        $display("test interval range done");
        // 25 cycles of activity with reads running alongside
        fork
            pins(1'b1, 1'b0, 1'b0, 25);
            begin
                repeat (5) rd(hours_pkg::REG_INTERVAL, 32'd3);
                rd(hours_pkg::REG_STATUS, 32'h2);
            end
        join
        rd(hours_pkg::REG_REMAIN, 32'd1);
        rd(hours_pkg::REG_ACCUM, 32'd2);
        pin_chk(1'b0, 1'b0);
        pins(1'b1, 1'b0, 1'b0, 10);
        rd(hours_pkg::REG_REMAIN, 32'd0);
        rd(hours_pkg::REG_STATUS, 32'h1);
        pin_chk(1'b1, 1'b0);
        pins(1'b1, 1'b0, 1'b0, 20);
        rd(hours_pkg::REG_REMAIN, 32'd0);
        rd(hours_pkg::REG_ACCUM, 32'd5);
        pin_chk(1'b1, 1'b0);
        $display("test counting done");
        rd(hours_pkg::REG_IRQ_STAT, 32'h5);
        wr(hours_pkg::REG_IRQ_MASK, 32'h1);
        pin_chk(1'b1, 1'b1);
        wr(hours_pkg::REG_IRQ_STAT, 32'h1);
        rd(hours_pkg::REG_IRQ_STAT, 32'h4);
        pin_chk(1'b1, 1'b0);
        wr(hours_pkg::REG_IRQ_MASK, 32'h4);
        pin_chk(1'b1, 1'b1);
        wr(hours_pkg::REG_IRQ_STAT, 32'h4);
        pin_chk(1'b1, 1'b0);
        $display("test interrupts done");
        // activity while the partial reset is held must not count
        fork
            pins(1'b1, 1'b1, 1'b0, 30);
            begin
                cyc(10);
                pin_chk(1'b0, 1'b0);
                rd(hours_pkg::REG_STATUS, 32'h4);
            end
        join
        rd(hours_pkg::REG_REMAIN, 32'd3);
        rd(hours_pkg::REG_ACCUM, 32'd5);
        pin_chk(1'b0, 1'b0);
        pins(1'b1, 1'b0, 1'b1, 30);
        rd(hours_pkg::REG_REMAIN, 32'd3);
        rd(hours_pkg::REG_ACCUM, 32'd0);
        $display("test reset inputs done");
        wr(hours_pkg::REG_INTERVAL, 32'd0);
        pins(1'b0, 1'b0, 1'b1, 4);
        rd(hours_pkg::REG_REMAIN, 32'd0);
        pin_chk(1'b1, 1'b0);
        $display("test zero interval done");
        cyc(4);
        finish_test();
    end
endmodule
